// >>> hw/timer_spc_pkg.sv
// Constants for the single-pulse and capture timer block
package timer_spc_pkg;

  // ==========================================================
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] RUN_OFS = 8'h00;
  localparam logic [7:0] CTRL_ONE_OFS = 8'h04;
  localparam logic [7:0] CMP_A_OFS = 8'h08;
  localparam logic [7:0] CMP_P_OFS = 8'h0C;
  localparam logic [7:0] COUNT_OFS = 8'h10;
  localparam int ADDR_BITS = 8;

  // ==========================================================
  // Field positions in timer_control_one and the run register
  localparam int MODE_LO_POS = 0;
  localparam int MODE_HI_POS = 1;
  localparam int PIN_LO_POS = 2;
  localparam int PIN_HI_POS = 3;
  localparam int OUT_INIT_POS = 4;
  localparam int OUT_POL_POS = 5;
  localparam int DPX_POS = 6;
  localparam int CCLR_POS = 7;
  localparam int CTRL_BITS = 8;
  localparam int RUN_POS = 0;

  // ==========================================================
  // Mode and pin-function encodings
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM_PULSE = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] PIN_RISE = 2'h0;
  localparam logic [1:0] PIN_FALL = 2'h1;
  localparam logic [1:0] PIN_BOTH = 2'h2;
  localparam logic [1:0] PIN_PULSE = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CMP_A_RESET = 16'h0000;
  localparam logic [7:0] CMP_P_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_POS = 1;

endpackage

// >>> hw/timer_single_pulse_capture.sv
// Single-pulse output and capture-input timer with an AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none

module timer_single_pulse_capture #(
  parameter int CNT_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic externalTriggerPin,
  input wire logic capturePin,
  output logic pulseOut,
  output logic pulseOutEnN,
  output logic timerReq
);

  // ==========================================================
  // Bus slave
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdMux;
  logic addrTaken;
  logic wrEn;

  // Register state
  logic run_q;
  logic runPrev_q;
  logic [7:0] ctrl_q;
  logic [CNT_BITS-1:0] cmpA_q;
  logic [7:0] cmpP_q;
  logic [CNT_BITS-1:0] cnt_q;
  logic [CNT_BITS-1:0] cntNext;
  logic trigPrev_q;
  logic capPrev_q;
  logic pulseOut_q;
  logic pulseOutEnN_q;
  logic timerReq_q;

  // Decoded control
  logic [1:0] modeSel;
  logic [1:0] pinFunc;
  logic outPol;
  logic spMode;
  logic capMode;
  logic runRise;
  logic trigEdge;
  logic capHit;
  logic aMatch;
  logic pMatch;
  logic runD;

  // Frozen clock enable also stalls the bus, so no transfer is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign addrTaken = ce & hready & hsel & htrans[timer_spc_pkg::HTRANS_ACTIVE_POS];
  assign wrEn = ce & wrPend_q;

  // Read mux, unmapped offsets read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[timer_spc_pkg::ADDR_BITS-1:0])
      timer_spc_pkg::RUN_OFS: rdMux[timer_spc_pkg::RUN_POS] = run_q;
      timer_spc_pkg::CTRL_ONE_OFS: rdMux[7:0] = ctrl_q;
      timer_spc_pkg::CMP_A_OFS: rdMux[CNT_BITS-1:0] = cmpA_q;
      timer_spc_pkg::CMP_P_OFS: rdMux[7:0] = cmpP_q;
      timer_spc_pkg::COUNT_OFS: rdMux[CNT_BITS-1:0] = cnt_q;
      default: rdMux = 32'h0000_0000;
    endcase
    if (haddr[31:timer_spc_pkg::ADDR_BITS] != 24'h00_0000) begin
      rdMux = 32'h0000_0000;
    end
  end

  // Address phase: read data registered at once, giving zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else if (ce & hready) begin
      wrPend_q <= addrTaken & hwrite;
      if (addrTaken & hwrite) begin
        wrAddr_q <= (haddr[31:timer_spc_pkg::ADDR_BITS] == 24'h00_0000) ?
                    haddr[7:0] : 8'hFF;
      end
      if (addrTaken & ~hwrite) begin
        hrdata_q <= rdMux;
      end
    end
  end

  // ==========================================================
  // Mode decode
  assign modeSel = {ctrl_q[timer_spc_pkg::MODE_HI_POS],
                    ctrl_q[timer_spc_pkg::MODE_LO_POS]};
  assign pinFunc = {ctrl_q[timer_spc_pkg::PIN_HI_POS],
                    ctrl_q[timer_spc_pkg::PIN_LO_POS]};
  assign outPol = ctrl_q[timer_spc_pkg::OUT_POL_POS];
  assign spMode = (modeSel == timer_spc_pkg::MODE_PWM_PULSE) &&
                  (pinFunc == timer_spc_pkg::PIN_PULSE);
  assign capMode = (modeSel == timer_spc_pkg::MODE_CAPTURE);

  // Event detection; pins are synchronous so one history flop suffices
  assign runRise = run_q & ~runPrev_q;
  assign trigEdge = externalTriggerPin & ~trigPrev_q;
  assign cntNext = cnt_q + {{(CNT_BITS-1){1'b0}}, 1'b1};
  assign aMatch = run_q & ~runRise & (cnt_q == cmpA_q);
  // Upper byte match at the wrap point; zero matches the natural overflow
  assign pMatch = run_q & (cntNext[7:0] == 8'h00) &&
                  (cntNext[CNT_BITS-1:8] == cmpP_q);

  // Capture edge select; 11 captures nothing
  always_comb begin
    unique case (pinFunc)
      timer_spc_pkg::PIN_RISE: capHit = capturePin & ~capPrev_q;
      timer_spc_pkg::PIN_FALL: capHit = ~capturePin & capPrev_q;
      timer_spc_pkg::PIN_BOTH: capHit = capturePin ^ capPrev_q;
      timer_spc_pkg::PIN_PULSE: capHit = 1'b0;
    endcase
    capHit = capHit & capMode;
  end

  // Pin history, taken whatever direction the shared pin has
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev_q <= 1'b0;
      capPrev_q <= 1'b0;
      runPrev_q <= 1'b0;
    end else if (ce) begin
      trigPrev_q <= externalTriggerPin;
      capPrev_q <= capturePin;
      runPrev_q <= run_q;
    end
  end

  // ==========================================================
  // Run bit: trigger set beats any clear in the same cycle
  always_comb begin
    runD = run_q;
    if (wrEn && wrAddr_q == timer_spc_pkg::RUN_OFS) begin
      runD = hwdata[timer_spc_pkg::RUN_POS];
    end
    if (spMode & aMatch) begin
      runD = 1'b0;
    end
    if (spMode & trigEdge) begin
      runD = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (ce) begin
      run_q <= runD;
    end
  end

  // Control and compare P registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= timer_spc_pkg::CTRL_RESET;
      cmpP_q <= timer_spc_pkg::CMP_P_RESET;
    end else if (wrEn) begin
      if (wrAddr_q == timer_spc_pkg::CTRL_ONE_OFS) begin
        ctrl_q <= hwdata[timer_spc_pkg::CTRL_BITS-1:0];
      end
      if (wrAddr_q == timer_spc_pkg::CMP_P_OFS) begin
        cmpP_q <= hwdata[7:0];
      end
    end
  end

  // Compare A: a capture wins over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmpA_q <= timer_spc_pkg::CMP_A_RESET;
    end else if (ce) begin
      if (capHit) begin
        cmpA_q <= cnt_q;
      end else if (wrEn && wrAddr_q == timer_spc_pkg::CMP_A_OFS) begin
        cmpA_q <= hwdata[CNT_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // Counter: held while stopped, cleared on restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= timer_spc_pkg::COUNT_RESET;
    end else if (ce) begin
      if (runRise) begin
        cnt_q <= '0;
      end else if (run_q & spMode & aMatch) begin
        cnt_q <= cnt_q;
      end else if (run_q & capMode & pMatch) begin
        cnt_q <= '0;
      end else if (run_q) begin
        cnt_q <= cntNext;
      end
    end
  end

  // Output pin: idle level is the polarity bit, pulse while running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulseOut_q <= 1'b0;
      pulseOutEnN_q <= 1'b1;
    end else if (ce) begin
      pulseOut_q <= spMode ? (runD ^ outPol) : 1'b0;
      pulseOutEnN_q <= ~spMode;
    end
  end

  // Interrupt request pulse, one enabled cycle per event
  // Held like all other state while the clock enable is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerReq_q <= 1'b0;
    end else if (ce) begin
      timerReq_q <= (spMode & aMatch) |
                    (capMode & (capHit | pMatch));
    end
  end

  assign pulseOut = pulseOut_q;
  assign pulseOutEnN = pulseOutEnN_q;
  assign timerReq = timerReq_q;

  // ==========================================================
  // Checks
  a_trigger_sets_run: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && trigEdge |=> run_q)
    else $error("trigger edge did not set run");

  // Outside pulse mode only software may move the run bit
  a_trigger_ignored: assert property (
    @(posedge clk) disable iff (rst)
    ce && !spMode && !(wrEn && wrAddr_q == timer_spc_pkg::RUN_OFS)
    |=> $stable(run_q))
    else $error("run bit changed outside pulse mode");

  // Polarity taken from the match cycle, as a control write may follow
  a_match_stops_run: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && aMatch && !trigEdge
    |=> !run_q && pulseOut_q == $past(outPol))
    else $error("compare A match did not end the pulse");

  a_match_raises_req: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && aMatch |=> timerReq_q)
    else $error("compare A match gave no request");

  a_restart_clears: assert property (
    @(posedge clk) disable iff (rst)
    ce && run_q && !runPrev_q |=> cnt_q == '0)
    else $error("counter not cleared on restart");

  a_stop_holds_count: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && !run_q |=> $stable(cnt_q))
    else $error("stopped pulse counter moved");

  a_pulse_ignores_p: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && run_q && !runRise && !aMatch
    |=> cnt_q == $past(cntNext))
    else $error("pulse counter did not advance");

  a_soft_stop_ends: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode && wrEn && wrAddr_q == timer_spc_pkg::RUN_OFS &&
    !hwdata[timer_spc_pkg::RUN_POS] && !trigEdge
    |=> !run_q && pulseOut_q == $past(outPol))
    else $error("software stop did not end the pulse");

  a_pulse_drives_pin: assert property (
    @(posedge clk) disable iff (rst)
    ce && spMode |=> !pulseOutEnN_q)
    else $error("pulse mode left the pin undriven");

  a_capture_latch: assert property (
    @(posedge clk) disable iff (rst)
    ce && capHit |=> cmpA_q == $past(cnt_q) && timerReq_q)
    else $error("capture did not latch counter");

  a_capture_counts: assert property (
    @(posedge clk) disable iff (rst)
    ce && capMode && run_q && runPrev_q && !pMatch
    |=> cnt_q == $past(cntNext))
    else $error("capture counter did not advance");

  a_pmatch_wraps: assert property (
    @(posedge clk) disable iff (rst)
    ce && capMode && runPrev_q && pMatch |=> cnt_q == '0 && timerReq_q)
    else $error("compare P match did not wrap counter");

  a_full_range: assert property (
    @(posedge clk) disable iff (rst)
    ce && capMode && cmpP_q == 8'h00 && run_q && runPrev_q &&
    cnt_q == 16'hFFFF |=> cnt_q == 16'h0000)
    else $error("full range wrap failed");

  a_capture_no_out: assert property (
    @(posedge clk) disable iff (rst)
    ce && capMode |=> pulseOutEnN_q && !pulseOut_q)
    else $error("capture mode drove the output");

  a_pin11_no_cap: assert property (
    @(posedge clk) disable iff (rst)
    capMode && pinFunc == timer_spc_pkg::PIN_PULSE |-> !capHit)
    else $error("capture occurred with edges disabled");

endmodule

`default_nettype wire

// >>> verification/signal_source.sv
// Model of the trigger and capture sources that drive the timer pins
`timescale 1ns/100ps
`default_nettype none
module signal_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic capLevel,
  output logic externalTriggerPin,
  output logic capturePin
);
  logic [1:0] hold_q;
  // ==========================================
  // Trigger pulse held three cycles, then back low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 2'h0;
    end else if (fire) begin
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  assign externalTriggerPin = (hold_q != 2'h0);
  // Capture source follows the requested level a cycle late
  always_ff @(posedge clk) begin
    capturePin <= capLevel;
  end
endmodule
`default_nettype wire

// >>> verification/timer_single_pulse_capture_bench.sv
// Self-checking bench for the single-pulse and capture timer
`timescale 1ns/100ps
`default_nettype none
module timer_single_pulse_capture_bench;
  typedef struct {
    logic [7:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic fire = 1'b0;
  logic capLevel = 1'b0;
  logic ce = 1'b1;
  logic hreadyout, hresp, extTrig, capPin, pulseOut, pulseOutEnN, timerReq;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  int m;
  int expN[4] = '{1, 1, 2, 0};
  row_s rows[5] = '{
    '{timer_spc_pkg::CMP_P_OFS, 32'hFFFF_FF12, 32'h0000_0012},
    '{timer_spc_pkg::CMP_A_OFS, 32'h1234_5678, 32'h0000_5678},
    '{timer_spc_pkg::CTRL_ONE_OFS, 32'h0000_01FF, 32'h0000_00FF},
    '{timer_spc_pkg::COUNT_OFS, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}
  };
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  // Size tied: one slave, word transfers only
  timer_single_pulse_capture dut (.clk(clk), .rst(rst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .externalTriggerPin(extTrig), .capturePin(capPin),
    .pulseOut(pulseOut), .pulseOutEnN(pulseOutEnN), .timerReq(timerReq));
  signal_source src (.clk(clk), .rst(rst), .fire(fire),
    .capLevel(capLevel), .externalTriggerPin(extTrig),
    .capturePin(capPin));
  // ==========================================
  // Verdict, compare and bus helpers
  task automatic end_sim();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic waitRdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      if (k++ > 20) begin
        num_errors++;
        end_sim();
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] wd,
                     input logic w, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitRdy();
    r = hrdata;
  endtask
  // Counts request pulses, optionally toggling the capture source
  task automatic count(input int cycles, input logic tog, output int reqs);
    reqs = 0;
    repeat (cycles) begin
      @(posedge clk);
      if (tog) capLevel <= ~capLevel;
      @(negedge clk);
      if (timerReq === 1'b1) reqs++;
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (11) @(posedge clk);
    @(negedge clk);
    chk("enable in reset", pulseOutEnN, 1);
    chk("request in reset", timerReq, 0);
    chk("response in reset", hresp, 0);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(8'(4 * i), 0, 1'b0, rd);
      chk("reset value", rd, 0);
      chk("response okay", hresp, 0);
    end
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].wd, 1'b1, rd);
      bus(rows[i].a, 0, 1'b0, rd);
      chk("readback", rd, rows[i].exp);
    end
    // Pulse mode with swap and clear select set, which must not matter
    bus(timer_spc_pkg::CTRL_ONE_OFS, 32'h0000_00CE, 1'b1, rd);
    bus(timer_spc_pkg::CMP_A_OFS, 32'h0000_0005, 1'b1, rd);
    bus(timer_spc_pkg::CMP_P_OFS, 32'h0000_0001, 1'b1, rd);
    @(negedge clk);
    chk("pulse enable", pulseOutEnN, 0);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    n = 0;
    while (pulseOut !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("pulse start", pulseOut, 1);
    n = 0;
    while (pulseOut === 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("pulse width", n, 7);
    chk("match request", timerReq, 1);
    bus(timer_spc_pkg::COUNT_OFS, 0, 1'b0, rd);
    chk("count holds", rd, 5);
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b0, rd);
    chk("run cleared", rd, 0);
    bus(timer_spc_pkg::CMP_A_OFS, 32'h0000_0100, 1'b1, rd);
    bus(timer_spc_pkg::RUN_OFS, 32'h0000_0001, 1'b1, rd);
    @(negedge clk);
    chk("soft start", pulseOut, 1);
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b1, rd);
    @(negedge clk);
    chk("soft end", pulseOut, 0);
    // Capture mode, level and polarity bits set to show they are ignored
    bus(timer_spc_pkg::CMP_P_OFS, 0, 1'b1, rd);
    bus(timer_spc_pkg::CTRL_ONE_OFS, 32'h0000_0031, 1'b1, rd);
    @(posedge clk);
    fire <= 1'b1;
    count(6, 1'b0, n);
    @(posedge clk);
    fire <= 1'b0;
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b0, rd);
    chk("trigger ignored", rd, 0);
    bus(timer_spc_pkg::RUN_OFS, 32'h0000_0001, 1'b1, rd);
    for (int p = 0; p < 4; p++) begin
      bus(timer_spc_pkg::CTRL_ONE_OFS, 32'h0000_0031 | 32'(p << 2), 1'b1,
          rd);
      bus(timer_spc_pkg::CMP_A_OFS, 0, 1'b1, rd);
      @(posedge clk);
      capLevel <= 1'b1;
      count(6, 1'b0, n);
      @(posedge clk);
      capLevel <= 1'b0;
      count(6, 1'b0, m);
      chk("capture edges", n + m, expN[p]);
      bus(timer_spc_pkg::CMP_A_OFS, 0, 1'b0, rd);
      chk("captured", rd != 0, p != 3);
      chk("no output", {pulseOutEnN, pulseOut}, 2);
    end
    // Compare P of one bounds the count at 256
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b1, rd);
    bus(timer_spc_pkg::CMP_P_OFS, 32'h0000_0001, 1'b1, rd);
    bus(timer_spc_pkg::CTRL_ONE_OFS, 32'h0000_003D, 1'b1, rd);
    bus(timer_spc_pkg::RUN_OFS, 32'h0000_0001, 1'b1, rd);
    count(600, 1'b1, n);
    chk("P wraps", n, 2);
    bus(timer_spc_pkg::COUNT_OFS, 0, 1'b0, rd);
    chk("count bound", rd < 32'd256, 1);
    // Compare P of zero runs the full 16-bit range
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b1, rd);
    bus(timer_spc_pkg::CMP_P_OFS, 0, 1'b1, rd);
    bus(timer_spc_pkg::RUN_OFS, 32'h0000_0001, 1'b1, rd);
    count(65600, 1'b0, n);
    chk("full wrap", n, 1);
    // Clock enable low freezes the counter and stalls the bus
    // Four enabled edges lie between the two counter samples
    bus(timer_spc_pkg::COUNT_OFS, 0, 1'b0, rd);
    m = rd;
    @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("bus stalled", hreadyout, 0);
    @(posedge clk);
    ce <= 1'b1;
    bus(timer_spc_pkg::COUNT_OFS, 0, 1'b0, rd);
    chk("frozen count", rd - m, 4);
    // Reset in mid-run brings outputs and registers back to idle
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("mid reset enable", pulseOutEnN, 1);
    chk("mid reset request", timerReq, 0);
    chk("mid reset response", hresp, 0);
    @(posedge clk);
    rst <= 1'b0;
    bus(timer_spc_pkg::COUNT_OFS, 0, 1'b0, rd);
    chk("mid reset count", rd, 0);
    bus(timer_spc_pkg::CTRL_ONE_OFS, 0, 1'b0, rd);
    chk("mid reset control", rd, 0);
    bus(timer_spc_pkg::RUN_OFS, 0, 1'b0, rd);
    chk("mid reset run", rd, 0);
    end_sim();
  end
endmodule
`default_nettype wire
